//--- rtl/vtas_pkg.sv
// Constants, types and step programs of the teach and autotune sequencer
package vtas_pkg;

  // Clock and tick
  localparam int CLK_MHZ  = 250;
  localparam int MS_CYC   = CLK_MHZ * 1000;

  // Button hold times and waits in seconds, then in ms ticks
  localparam real TEACH_S    = 1.5;
  localparam real CLEAR_S    = 2.5;
  localparam real ATM_S      = 2.5;
  localparam real SEL_S      = 0.5;
  localparam real IDLE_S     = 10.0;
  localparam real SOL_WAIT_S = 10.0;
  localparam real FB_TOUT_S  = 15.0;
  localparam int  TEACH_MS    = int'(TEACH_S * 1000.0);
  localparam int  CLEAR_MS    = int'(CLEAR_S * 1000.0);
  localparam int  ATM_MS      = int'(ATM_S * 1000.0);
  localparam int  SEL_MS      = int'(SEL_S * 1000.0);
  localparam int  IDLE_MS     = int'(IDLE_S * 1000.0);
  localparam int  SOL_WAIT_MS = int'(SOL_WAIT_S * 1000.0);
  localparam int  FB_TOUT_MS  = int'(FB_TOUT_S * 1000.0);

  // Blink half periods in ms and flash half-period count
  localparam int       FAST_MS      = 100;
  localparam int       SLOW_MS      = 500;
  localparam int       CHASE_MS     = 150;
  localparam bit [2:0] FLASH_HALVES = 3'h6;

  // Widths
  localparam int NBTN   = 3;
  localparam int POS_W  = 8;
  localparam int HOLD_W = 12;
  localparam int TMR_W  = 16;

  // Button combinations
  localparam bit [2:0] BTN_NONE = 3'h0;
  localparam bit [2:0] BTN_LOW  = 3'h1;
  localparam bit [2:0] BTN_HIGH = 3'h2;
  localparam bit [2:0] BTN_MID  = 3'h4;
  localparam bit [2:0] BTN_LH   = 3'h3;
  localparam bit [2:0] BTN_LM   = 3'h5;
  localparam bit [2:0] BTN_HM   = 3'h6;

  // Register byte offsets
  localparam bit [7:0] REG_CTRL     = 8'h00;
  localparam bit [7:0] REG_FIELD    = 8'h04;
  localparam bit [7:0] REG_STATUS   = 8'h08;
  localparam bit [7:0] REG_SLOT0    = 8'h0C;
  localparam bit [7:0] REG_SLOT1    = 8'h10;
  localparam bit [7:0] REG_SLOT2    = 8'h14;
  localparam bit [7:0] REG_IRQ_STAT = 8'h18;
  localparam bit [7:0] REG_IRQ_EN   = 8'h1C;
  localparam bit [7:0] REG_IRQ_CLR  = 8'h20;

  // Reset values and field positions
  localparam bit [POS_W-1:0] FIELD_RST = 8'h06;
  localparam int CTRL_ABORT = 0;
  localparam int NIRQ       = 5;
  localparam int IRQ_STORED = 0;
  localparam int IRQ_TFAULT = 1;
  localparam int IRQ_CLEAR  = 2;
  localparam int IRQ_DONE   = 3;
  localparam int IRQ_FAIL   = 4;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_TEACH, ST_TFAULT, ST_ATM, ST_RUN
  } vtas_state_t;

  typedef enum logic [2:0] {
    OP_TEACH, OP_SOL, OP_WAIT, OP_FB, OP_DONE
  } vtas_op_t;

  typedef struct packed {
    vtas_op_t   op;
    logic [1:0] arg;
  } vtas_step_t;

  typedef struct packed {
    logic [2:0] slot;
    logic [2:0] fault;
  } vtas_led_t;

  typedef struct packed {
    vtas_state_t state;
    logic [2:0]  fn;
    logic [1:0]  sol;
    logic [2:0]  taught;
    logic [2:0]  fb;
  } vtas_status_t;

  // Step of autotune program fn; sol arg is {solenoid_two, solenoid_one}
  function automatic vtas_step_t vtas_prog(input logic [2:0] fn,
                                           input logic [3:0] idx);
    vtas_step_t s;
    s = '{OP_DONE, 2'h0};
    if (fn == 3'h4) begin
      case (idx)
        4'h0: s = '{OP_SOL, 2'h2};
        4'h1: s = '{OP_WAIT, 2'h0};
        4'h2: s = '{OP_TEACH, 2'h0};
        4'h3: s = '{OP_SOL, 2'h1};
        4'h4: s = '{OP_WAIT, 2'h0};
        4'h5: s = '{OP_TEACH, 2'h1};
        4'h6: s = '{OP_SOL, 2'h2};
        4'h7: s = '{OP_FB, 2'h0};
        4'h8: s = '{OP_SOL, 2'h0};
        default: s = '{OP_DONE, 2'h0};
      endcase
    end else begin
      case (idx)
        4'h0: s = '{OP_TEACH, (fn == 3'h2) ? 2'h1 : 2'h0};
        4'h1: s = '{OP_SOL, 2'h1};
        4'h2: s = '{OP_WAIT, 2'h0};
        4'h3: s = '{OP_TEACH, (fn == 3'h2) ? 2'h0 : 2'h1};
        4'h4: s = '{OP_SOL, 2'h0};
        4'h5: s = '{OP_FB, (fn == 3'h2) ? 2'h1 : 2'h0};
        4'h6: s = (fn == 3'h3) ? '{OP_SOL, 2'h2} : '{OP_DONE, 2'h0};
        4'h7: s = '{OP_WAIT, 2'h0};
        4'h8: s = '{OP_TEACH, 2'h2};
        4'h9: s = '{OP_SOL, 2'h0};
        4'hA: s = '{OP_FB, 2'h0};
        default: s = '{OP_DONE, 2'h0};
      endcase
    end
    return s;
  endfunction : vtas_prog

endpackage : vtas_pkg

//--- rtl/vtas_btn_hold.sv
// Button synchroniser and hold-time meter of the teach sequencer
`timescale 1ns/1ps
`default_nettype none
module vtas_btn_hold
  import vtas_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              ms_tick,
  input  wire logic [NBTN-1:0]   btn_pin,
  output logic      [NBTN-1:0]   combo,
  output logic      [HOLD_W-1:0] hold_ms,
  output logic                   press
);

  logic [NBTN-1:0]   meta_r;
  logic [NBTN-1:0]   sync_r;
  logic [NBTN-1:0]   combo_r;
  logic [NBTN-1:0]   combo_nxt;
  logic [HOLD_W-1:0] hold_r;
  logic [HOLD_W-1:0] hold_nxt;
  logic              press_nxt;
  logic              press_r;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers, one per button
  for (genvar i = 0; i < NBTN; i++) begin : g_sync
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= btn_pin[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hold time restarts whenever the combination changes
  always_comb begin
    combo_nxt = sync_r;
    press_nxt = (sync_r != combo_r) && (sync_r != BTN_NONE);
    hold_nxt  = hold_r;
    if (sync_r != combo_r) begin
      hold_nxt = '0;
    end else if (ms_tick && (hold_r != '1)) begin
      hold_nxt = hold_r + 1'b1;
    end
  end

  // Registers of the meter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      combo_r <= '0;
      hold_r  <= '0;
      press_r <= 1'b0;
    end else begin
      combo_r <= combo_nxt;
      hold_r  <= hold_nxt;
      press_r <= press_nxt;
    end
  end

  assign combo   = combo_r;
  assign hold_ms = hold_r;
  assign press   = press_r;

endmodule : vtas_btn_hold
`default_nettype wire

//--- rtl/vtas_seq.sv
// Teach and autotune sequencer of a valve control head, APB registers
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vtas_seq
  import vtas_pkg::*;
#(
  parameter int TICK_CYC     = MS_CYC,
  parameter int IDLE_TMO     = IDLE_MS,
  parameter int SOL_WAIT_TMO = SOL_WAIT_MS,
  parameter int FB_TMO       = FB_TOUT_MS
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             teach_button_low,
  input  wire logic             teach_button_high,
  input  wire logic             teach_button_middle,
  input  wire logic [POS_W-1:0] pos_value,
  input  wire logic             pos_in_range,
  output logic                  solenoid_one,
  output logic                  solenoid_two,
  output logic                  position_one_feedback,
  output logic                  position_two_feedback,
  output logic                  position_three_feedback,
  output vtas_led_t             led,
  output logic                  irq
);

  // Ms tick and blink
  logic [31:0]       tick_cnt_r, tick_cnt_nxt;
  logic              tick_r, tick_nxt;
  logic [TMR_W-1:0]  slow_ms_r, slow_ms_nxt;
  logic              slow_r, slow_nxt;
  logic [TMR_W-1:0]  chase_ms_r, chase_ms_nxt;
  logic [1:0]        chase_r, chase_nxt;
  // Buttons
  logic [2:0]        combo;
  logic [HOLD_W-1:0] hold_ms;
  logic              press;
  // Sequencer
  vtas_state_t       st_r, st_nxt;
  logic [2:0]        fn_r, fn_nxt;
  logic [3:0]        step_r, step_nxt;
  logic [TMR_W-1:0]  tmr_r, tmr_nxt;
  logic [2:0]        flc_r, flc_nxt;
  logic [1:0]        tslot_r, tslot_nxt;
  logic [POS_W-1:0]  slot_r [3];
  logic [POS_W-1:0]  slot_nxt [3];
  logic [2:0]        taught_r, taught_nxt;
  logic [2:0]        mask_r, mask_nxt;
  logic [1:0]        sol_r, sol_nxt;
  logic [2:0]        fb_r, fb_nxt;
  vtas_led_t         led_r, led_nxt;
  logic [NIRQ-1:0]   evt;
  vtas_step_t        stp;
  // Registers
  logic [POS_W-1:0]  field_r, field_nxt;
  logic [NIRQ-1:0]   irq_st_r, irq_st_nxt;
  logic [NIRQ-1:0]   irq_en_r, irq_en_nxt;
  logic              abort_r, abort_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              pslverr_r, pslverr_nxt;
  vtas_status_t      status;

  // Exact combination reaching its hold time this tick
  function automatic logic hit(input logic [2:0] want,
                               input int         ms);
    return (combo == want) && tick_r &&
           (hold_ms == HOLD_W'(ms - 1));
  endfunction : hit

  // Mapped register offsets
  function automatic logic reg_ok(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_FIELD) || (a == REG_STATUS) ||
           (a == REG_SLOT0) || (a == REG_SLOT1) || (a == REG_SLOT2) ||
           (a == REG_IRQ_STAT) || (a == REG_IRQ_EN) ||
           (a == REG_IRQ_CLR);
  endfunction : reg_ok

  vtas_btn_hold u_hold (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ms_tick (tick_r),
    .btn_pin ({teach_button_middle, teach_button_high, teach_button_low}),
    .combo   (combo),
    .hold_ms (hold_ms),
    .press   (press)
  );

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick, slow blink and running light
  always_comb begin
    tick_nxt     = (tick_cnt_r == 32'(TICK_CYC - 1));
    tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 1'b1;
    slow_ms_nxt  = slow_ms_r;
    slow_nxt     = slow_r;
    chase_ms_nxt = chase_ms_r;
    chase_nxt    = chase_r;
    if (tick_r) begin
      slow_ms_nxt  = slow_ms_r + 1'b1;
      chase_ms_nxt = chase_ms_r + 1'b1;
      if (slow_ms_r == TMR_W'(SLOW_MS - 1)) begin
        slow_ms_nxt = '0;
        slow_nxt    = !slow_r;
      end
      if (chase_ms_r == TMR_W'(CHASE_MS - 1)) begin
        chase_ms_nxt = '0;
        chase_nxt    = (chase_r == 2'h2) ? 2'h0 : chase_r + 1'b1;
      end
    end
  end

  // Tick and blink registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
      slow_ms_r  <= '0;
      slow_r     <= 1'b0;
      chase_ms_r <= '0;
      chase_r    <= 2'h0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
      slow_ms_r  <= slow_ms_nxt;
      slow_r     <= slow_nxt;
      chase_ms_r <= chase_ms_nxt;
      chase_r    <= chase_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    st_nxt     = st_r;
    fn_nxt     = fn_r;
    step_nxt   = step_r;
    tmr_nxt    = tick_r ? tmr_r + 1'b1 : tmr_r;
    flc_nxt    = flc_r;
    tslot_nxt  = tslot_r;
    slot_nxt   = slot_r;
    taught_nxt = taught_r;
    mask_nxt   = mask_r;
    sol_nxt    = sol_r;
    evt        = '0;
    stp        = vtas_prog(fn_r, step_r);
    case (st_r)
      ST_NORMAL: begin
        tmr_nxt = '0;
        flc_nxt = '0;
        // exact hold; any slot, any position
        if (hit(BTN_LOW, TEACH_MS)) begin
          st_nxt    = ST_TEACH;
          tslot_nxt = 2'h0;
        end else if (hit(BTN_HIGH, TEACH_MS)) begin
          st_nxt    = ST_TEACH;
          tslot_nxt = 2'h1;
        end else if (hit(BTN_MID, TEACH_MS)) begin
          st_nxt    = ST_TEACH;
          tslot_nxt = 2'h2;
        end else if (hit(BTN_LH, CLEAR_MS)) begin
          taught_nxt     = '0;
          evt[IRQ_CLEAR] = 1'b1;
        end else if (hit(BTN_HM, ATM_MS)) begin
          st_nxt = ST_ATM;
        end
      end
      ST_TEACH, ST_TFAULT: begin
        // three fast flashes before the outcome
        if (tick_r && (tmr_r == TMR_W'(FAST_MS - 1))) begin
          tmr_nxt = '0;
          flc_nxt = flc_r + 1'b1;
        end
        if (flc_r == FLASH_HALVES) begin
          flc_nxt = '0;
          tmr_nxt = '0;
          st_nxt  = ST_NORMAL;
          // out of range is flagged, nothing stored
          if (st_r == ST_TEACH && !pos_in_range) begin
            st_nxt          = ST_TFAULT;
            evt[IRQ_TFAULT] = 1'b1;
          end else if (st_r == ST_TEACH) begin
            slot_nxt[tslot_r] = pos_value;
            taught_nxt[tslot_r] = 1'b1;
            evt[IRQ_STORED]     = 1'b1;
          end
        end
      end
      ST_ATM: begin
        // leave when nothing starts in time
        if (tick_r && (tmr_r == TMR_W'(IDLE_TMO - 1))) begin
          st_nxt = ST_NORMAL;
        end else if ((combo != BTN_NONE) && hit(combo, SEL_MS)) begin
          fn_nxt   = (combo == BTN_LOW)  ? 3'h1 :
                     (combo == BTN_HIGH) ? 3'h2 :
                     (combo == BTN_MID)  ? 3'h3 :
                     (combo == BTN_LH)   ? 3'h4 :
                     (combo == BTN_LM)   ? 3'h5 : 3'h6;
          step_nxt = '0;
          tmr_nxt  = '0;
          mask_nxt = '0;
          st_nxt   = (combo == BTN_LM || combo == BTN_HM) ?
                     ST_NORMAL : ST_RUN;
        end
      end
      ST_RUN: begin
        case (stp.op)
          OP_TEACH: begin
            slot_nxt[stp.arg]   = pos_value;
            taught_nxt[stp.arg] = 1'b1;
            mask_nxt[stp.arg]   = 1'b1;
            step_nxt            = step_r + 1'b1;
            tmr_nxt             = '0;
          end
          OP_SOL: begin
            sol_nxt  = stp.arg;
            step_nxt = step_r + 1'b1;
            tmr_nxt  = '0;
          end
          OP_WAIT: begin
            if (tick_r && (tmr_r == TMR_W'(SOL_WAIT_TMO - 1))) begin
              step_nxt = step_r + 1'b1;
              tmr_nxt  = '0;
            end
          end
          OP_FB: begin
            if (fb_r[stp.arg]) begin
              step_nxt = step_r + 1'b1;
              tmr_nxt  = '0;
            end
          end
          default: begin
            sol_nxt       = 2'h0;
            st_nxt        = ST_NORMAL;
            evt[IRQ_DONE] = 1'b1;
          end
        endcase
        // failure, timeout or abort erases this run
        if ((stp.op == OP_TEACH && !pos_in_range) || press || abort_r ||
            (stp.op == OP_FB && !fb_r[stp.arg] && tick_r &&
             tmr_r == TMR_W'(FB_TMO - 1))) begin
          taught_nxt    = taught_r & ~mask_r;
          slot_nxt      = slot_r;
          sol_nxt       = 2'h0;
          step_nxt      = '0;
          st_nxt        = ST_NORMAL;
          evt[IRQ_DONE] = 1'b0;
          evt[IRQ_FAIL] = 1'b1;
        end
      end
      default: st_nxt = ST_NORMAL;
    endcase
  end

  // Slot feedback and LED patterns
  always_comb begin
    led_nxt = '0;
    for (int i = 0; i < 3; i++) begin
      // window around taught slot, only in range
      fb_nxt[i] = pos_in_range && taught_nxt[i] &&
                  ((pos_value >= slot_nxt[i]) ?
                   (pos_value - slot_nxt[i] <= field_r) :
                   (slot_nxt[i] - pos_value <= field_r));
      // steady or slow at position, untaught blinks fault
      led_nxt.slot[i]  = fb_r[i] && ((i != 2) || slow_r);
      led_nxt.fault[i] = pos_in_range && !taught_r[i] && slow_r;
    end
    if (st_r == ST_TEACH) begin
      led_nxt.slot[tslot_r] = !flc_r[0] && (flc_r != FLASH_HALVES);
    end else if (st_r == ST_TFAULT) begin
      // LED three flashes in fault colour
      led_nxt.fault[2] = !flc_r[0] && (flc_r != FLASH_HALVES);
    end else if (st_r == ST_ATM) begin
      // all on, running light while a press is held
      led_nxt.fault = '0;
      led_nxt.slot  = (combo == BTN_NONE) ? 3'h7 : 3'(3'h1 << chase_r);
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r     <= ST_NORMAL;
      fn_r     <= 3'h0;
      step_r   <= 4'h0;
      tmr_r    <= '0;
      flc_r    <= 3'h0;
      tslot_r  <= 2'h0;
      slot_r   <= '{default: '0};
      taught_r <= 3'h0;
      mask_r   <= 3'h0;
      sol_r    <= 2'h0;
      fb_r     <= 3'h0;
      led_r    <= '0;
    end else begin
      st_r     <= st_nxt;
      fn_r     <= fn_nxt;
      step_r   <= step_nxt;
      tmr_r    <= tmr_nxt;
      flc_r    <= flc_nxt;
      tslot_r  <= tslot_nxt;
      slot_r   <= slot_nxt;
      taught_r <= taught_nxt;
      mask_r   <= mask_nxt;
      sol_r    <= sol_nxt;
      fb_r     <= fb_nxt;
      led_r    <= led_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait state; read data sampled in setup phase
  assign status = '{st_r, fn_r, sol_r, taught_r, fb_r};

  always_comb begin
    field_nxt   = field_r;
    irq_en_nxt  = irq_en_r;
    abort_nxt   = 1'b0;
    irq_st_nxt  = irq_st_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      pslverr_nxt = !reg_ok(paddr);
      if (pwrite) begin
        prdata_nxt = '0;
      end else if (paddr == REG_FIELD) begin
        prdata_nxt = 32'(field_r);
      end else if (paddr == REG_STATUS) begin
        prdata_nxt = 32'(status);
      end else if (paddr == REG_SLOT0) begin
        prdata_nxt = 32'(slot_r[0]);
      end else if (paddr == REG_SLOT1) begin
        prdata_nxt = 32'(slot_r[1]);
      end else if (paddr == REG_SLOT2) begin
        prdata_nxt = 32'(slot_r[2]);
      end else if (paddr == REG_IRQ_STAT) begin
        prdata_nxt = 32'(irq_st_r);
      end else if (paddr == REG_IRQ_EN) begin
        prdata_nxt = 32'(irq_en_r);
      end else begin
        prdata_nxt = '0;
      end
    end else if (psel && penable) begin
      pslverr_nxt = pslverr_r;
    end
    if (psel && penable && pwrite) begin
      if (paddr == REG_CTRL) begin
        abort_nxt = pwdata[CTRL_ABORT];
      end else if (paddr == REG_FIELD) begin
        field_nxt = pwdata[POS_W-1:0];
      end else if (paddr == REG_IRQ_EN) begin
        irq_en_nxt = pwdata[NIRQ-1:0];
      end else if (paddr == REG_IRQ_CLR) begin
        irq_st_nxt = irq_st_r & ~pwdata[NIRQ-1:0];
      end
    end
    // New events win over a clear in the same cycle
    irq_st_nxt = irq_st_nxt | evt;
  end

  // Register file
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      field_r   <= FIELD_RST;
      irq_en_r  <= '0;
      irq_st_r  <= '0;
      abort_r   <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      field_r   <= field_nxt;
      irq_en_r  <= irq_en_nxt;
      irq_st_r  <= irq_st_nxt;
      abort_r   <= abort_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs
  assign prdata                  = prdata_r;
  assign pready                  = 1'b1;
  assign pslverr                 = pslverr_r & psel & penable;
  assign irq                     = |(irq_st_r & irq_en_r);
  assign solenoid_one            = sol_r[0];
  assign solenoid_two            = sol_r[1];
  assign position_one_feedback   = fb_r[0];
  assign position_two_feedback   = fb_r[1];
  assign position_three_feedback = fb_r[2];
  assign led                     = led_r;

endmodule : vtas_seq
`default_nettype wire

//--- verif/vtas_seq_assertions.sv
// Port checker of the teach and autotune sequencer
`timescale 1ns/1ps
`default_nettype none
module vtas_seq_chk
  import vtas_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pos_in_range,
  input wire logic        solenoid_one,
  input wire logic        solenoid_two,
  input wire logic        position_one_feedback,
  input wire logic        position_two_feedback,
  input wire logic        position_three_feedback,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Zero wait state slave
  a_ready_always: assert property (pready) else $error("pready low");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h20
    |-> pslverr) else $error("no error on unmapped address");
  a_err_mapped: assert property (psel && penable && paddr[1:0] == 2'h0
    && paddr <= 8'h20 |-> !pslverr) else $error("error on mapped address");
  a_rd_unmapped: assert property (psel && penable && !pwrite && pslverr
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_sol_excl: assert property (!(solenoid_one && solenoid_two))
    else $error("both solenoids on");
  a_fb_range: assert property (position_one_feedback ||
    position_two_feedback || position_three_feedback |-> $past(pos_in_range))
    else $error("feedback while out of range");
  a_reset_quiet: assert property ($rose(rstn) |-> !solenoid_one
    && !solenoid_two && !irq) else $error("outputs active after reset");
endmodule : vtas_seq_chk
bind vtas_seq vtas_seq_chk u_chk (.sys_clk, .rstn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .pos_in_range,
  .solenoid_one, .solenoid_two, .position_one_feedback,
  .position_two_feedback, .position_three_feedback, .irq);
`default_nettype wire

//--- verif/vtas_valve.sv
// Behavioural valve and position sensor in front of the sequencer
`timescale 1ns/1ps
`default_nettype none
module vtas_valve
  import vtas_pkg::*;
#(
  parameter int MOVE = 50
) (
  input  wire logic             sys_clk,
  input  wire logic             solenoid_one,
  input  wire logic             solenoid_two,
  input  wire logic             lost,
  output logic      [POS_W-1:0] pos_value,
  output logic                  pos_in_range
);
  logic [POS_W-1:0] p = 8'h20;
  logic [POS_W-1:0] tgt;
  int               cnt = 0;
  // End stop chosen by the solenoids: open, lift or closed
  assign tgt = solenoid_one ? 8'hC0 : (solenoid_two ? 8'h60 : 8'h20);
  // Piston reaches the stop some cycles after the solenoids change
  always @(posedge sys_clk) begin
    cnt <= (p == tgt) ? 0 : cnt + 1;
    if (cnt == MOVE) p <= tgt;
  end
  // Lost target gives a meaningless reading
  assign pos_value    = lost ? ~p : p;
  assign pos_in_range = !lost;
endmodule : vtas_valve
`default_nettype wire

//--- verif/tb_vtas_seq.sv
// Self-checking bench of the teach and autotune sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_vtas_seq
  import vtas_pkg::*;
;
  logic sys_clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, lost = 1'h0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, s1, s2, f1, f2, f3, irq, pir;
  logic [2:0] btn = 3'h0;
  logic [POS_W-1:0] pos;
  vtas_led_t led;
  int err_total = 0, n_tests = 0, flashes = 0;
  localparam int TK = 5;
  vtas_seq #(.TICK_CYC(TK), .IDLE_TMO(1000), .SOL_WAIT_TMO(20),
    .FB_TMO(30)) dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .teach_button_low(btn[0]),
    .teach_button_high(btn[1]), .teach_button_middle(btn[2]),
    .pos_value(pos), .pos_in_range(pir), .solenoid_one(s1),
    .solenoid_two(s2), .position_one_feedback(f1),
    .position_two_feedback(f2), .position_three_feedback(f3), .led, .irq);
  vtas_valve u_valve (.sys_clk, .solenoid_one(s1), .solenoid_two(s2),
    .lost, .pos_value(pos), .pos_in_range(pir));
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge led.slot[0]) flashes++;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic stuck();
    err_total++;
    results();
  endtask : stuck
  // One APB transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (pready === 1'h1) break;
    end
    if (i == 50) stuck();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
    int i;
    for (i = 0; i < 9000; i++) begin
      apb(1'h0, a, 32'h0);
      if ((rd & m) === v) break;
    end
    if (i == 9000) stuck();
  endtask : poll
  // Hold a button combination for ms ticks plus sync margin
  task automatic hold(input logic [2:0] c, input int ms);
    btn <= c;
    repeat (ms * TK + 40) @(posedge sys_clk);
    btn <= 3'h0;
    repeat (8) @(posedge sys_clk);
  endtask : hold
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk("sol", {s2, s1}, 2'h0);
    apb(1'h0, REG_FIELD, 32'h0);
    chk("field", rd, FIELD_RST);
    apb(1'h0, 8'h40, 32'h0);
    chk("slverr", er, 1'h1);
    apb(1'h1, REG_IRQ_EN, 32'h1F);
    hold(3'h1, TEACH_MS - 10);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("short", rd & 32'h3838, 32'h0);
    flashes = 0;
    hold(3'h1, TEACH_MS);
    poll(REG_STATUS, 32'h38, 32'h08);
    repeat (4) @(posedge sys_clk);
    chk("flash", flashes, 32'h4);
    chk("led", led.slot, 3'h1);
    chk("fb", {f3, f2, f1}, 3'h1);
    chk("irq", irq, 1'h1);
    apb(1'h0, REG_SLOT0, 32'h0);
    chk("slot0", rd, 32'h20);
    lost <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk("fb lost", {f3, f2, f1}, 3'h0);
    chk("led lost", led.slot, 3'h0);
    lost <= 1'h0;
    apb(1'h1, REG_IRQ_CLR, 32'h1F);
    @(posedge sys_clk);
    chk("irq clr", irq, 1'h0);
    hold(3'h6, ATM_MS);
    chk("atm led", led.slot, 3'h7);
    hold(3'h1, SEL_MS);
    poll(REG_IRQ_STAT, 32'h18, 32'h08);
    apb(1'h0, REG_SLOT1, 32'h0);
    chk("slot1", rd, 32'hC0);
    chk("sol end", {s2, s1}, 2'h0);
    // low and high together clear every slot
    hold(3'h3, CLEAR_MS);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("cleared", rd & 32'h38, 32'h0);
    apb(1'h0, REG_IRQ_STAT, 32'h0);
    chk("clr evt", rd & 32'h4, 32'h4);
    apb(1'h1, REG_IRQ_CLR, 32'h1F);
    // autotune four between the two solenoids
    hold(3'h6, ATM_MS);
    hold(3'h3, SEL_MS);
    poll(REG_IRQ_STAT, 32'h18, 32'h08);
    apb(1'h0, REG_SLOT0, 32'h0);
    chk("at4 slot0", rd, 32'h60);
    apb(1'h0, REG_SLOT1, 32'h0);
    chk("at4 slot1", rd, 32'hC0);
    chk("at4 sol", {s2, s1}, 2'h0);
    // autotune two aborted in its wait
    hold(3'h6, ATM_MS);
    hold(3'h2, SEL_MS);
    chk("at2 sol", {s2, s1}, 2'h1);
    apb(1'h1, REG_CTRL, 32'h1);
    poll(REG_IRQ_STAT, 32'h10, 32'h10);
    apb(1'h0, REG_STATUS, 32'h0);
    chk("at2 erase", rd & 32'h38F8, 32'h08);
    apb(1'h1, REG_IRQ_EN, 32'h0);
    @(posedge sys_clk);
    chk("irq mask", irq, 1'h0);
    results();
  end
endmodule : tb_vtas_seq
`default_nettype wire
